/* rtl/pllsh_pkg.sv */
// Constants, register map and carrier types for the serial host port and forwarding link.
// Assumes one system clock at 40 MHz that also stands in for the reference input.
// Operation
// [R1] Each frame outputs register chosen by pointer
// [R2] Unchanged pointer repeats same data each frame
// [R3] Host sets pointer via address-zero frame first
// [R4] Twenty-four data bits, MSB first, rising sample
// [R5] Five address bits follow on edges 25-29
// [R6] Host sends chip address 000 last
// [R7] Strobe rise commits data into addressed register
// [R8] Host lowers strobe after address frame
// [R9] Host resends same frame during readback
// [R10] Readback frame replaces lock with serial data
// [R11] Strobe rise restores lock indication
// [R12] Host follows recommended start-up write order
// [R13] Forward register write sends 16-bit packet
// [R14] Link rate from rate field, default ref/4
// [R15] Packet splits into select, index, payload
// [R16] Calibration updates only the payload field
// [R17] Calibration keeps select and index unchanged
// [R18] Host rewrites switch settings for manual reset
// [R19] Reset packet layout: caps, select, tune-off
// [R20] Address zero reads fixed identity, unwritable
// [R21] Address-zero write loads five-bit pointer
// [R22] Bit five of address-zero write soft-resets
// [R23] First clock edge before strobe picks mode
// [R24] Forward register reads last sent packet
// [R25] Frames for other chip addresses ignored

package pllsh_pkg;

    localparam int            DATA_W         = 24;
    localparam int            ADDR_W         = 5;
    localparam int            CHIP_W         = 3;
    localparam int            PKT_W          = 16;
    localparam int            FRAME_BITS     = 32;
    localparam int            CLK_PERIOD_NS  = 25;
    localparam int            LINK_MAX_MHZ   = 50;

    localparam logic [4:0]    ADDR_POINTER   = 5'h00;
    localparam logic [4:0]    ADDR_FORWARD   = 5'h05;
    localparam logic [4:0]    ADDR_LINK_RATE = 5'h0a;
    localparam logic [4:0]    ADDR_SWITCH    = 5'h10;
    localparam logic [2:0]    OWN_CHIP       = 3'h0;

    localparam int            SOFT_RESET_BIT = 5;
    localparam int            RATE_LSB       = 13;
    localparam int            RATE_MSB       = 14;
    localparam int            PAY_LSB        = 7;
    localparam int            PAY_MSB        = 15;
    localparam int            IDX_LSB        = 3;
    localparam int            IDX_MSB        = 6;
    localparam int            SEL_MSB        = 2;

    // Identity value is arbitrary
    localparam logic [23:0]   IDENTITY_VALUE = 24'h5a_0c3e;
    localparam logic [23:0]   REG_RESET      = 24'h00_0000;
    localparam logic [1:0]    RATE_RESET     = 2'h1;
    localparam logic [15:0]   FORWARD_RESET  = 16'h0000;
    localparam logic [4:0]    POINTER_RESET  = 5'h00;
    localparam logic [5:0]    COUNT_RESET    = 6'h00;

    typedef struct packed {
        logic [23:0] data;
        logic [4:0]  addr;
        logic [2:0]  chip;
    } pllsh_frame_t;

    typedef struct packed {
        logic clk;
        logic data;
        logic enable;
    } pllsh_link_t;

    typedef enum logic [1:0] {
        PLLSH_MODE_OPEN   = 2'b00,
        PLLSH_MODE_LEGACY = 2'b01,
        PLLSH_MODE_UNSET  = 2'b10
    } pllsh_mode_t;

    typedef enum logic {
        PLLSH_LINK_IDLE  = 1'b0,
        PLLSH_LINK_SHIFT = 1'b1
    } pllsh_link_state_t;

endpackage

/* rtl/pllsh_serial_port.sv */
// Serial host port in multi-device framing, register file and internal forwarding link.
// Assumes serial pins come from another domain; lock and calibration inputs are on clk.
`timescale 1ns/10ps

module pllsh_serial_port (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 serial_clk,
    input  wire logic                 frame_strobe,
    input  wire logic                 serial_data_in,
    input  wire logic                 lock_indicator,
    input  wire logic [7:0]           switch_settings,
    input  wire logic                 cal_payload_valid,
    input  wire logic [8:0]           cal_payload,
    output logic                      lock_or_serial_out,
    output logic                      multi_mode,
    output pllsh_pkg::pllsh_link_t    internal_forward_link
);
    import pllsh_pkg::*;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [2:0] sclk_sync_reg;
    logic [2:0] strobe_sync_reg;
    logic [2:0] sdi_sync_reg;
    logic       sclk_level_reg;
    logic       strobe_level_reg;
    logic       sclk_rise;
    logic       strobe_rise;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_sync_reg   <= 3'h0;
            strobe_sync_reg <= 3'h0;
            sdi_sync_reg    <= 3'h0;
        end else begin
            sclk_sync_reg   <= {sclk_sync_reg[1:0], serial_clk};
            strobe_sync_reg <= {strobe_sync_reg[1:0], frame_strobe};
            sdi_sync_reg    <= {sdi_sync_reg[1:0], serial_data_in};
        end
    end

    // Level follows only when second and third stage agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_level_reg   <= 1'b0;
            strobe_level_reg <= 1'b0;
        end else begin
            if (sclk_sync_reg[1] == sclk_sync_reg[2]) begin
                sclk_level_reg <= sclk_sync_reg[2];
            end
            if (strobe_sync_reg[1] == strobe_sync_reg[2]) begin
                strobe_level_reg <= strobe_sync_reg[2];
            end
        end
    end

    assign sclk_rise   = (sclk_sync_reg[1] == sclk_sync_reg[2]) && sclk_sync_reg[2]
                         && !sclk_level_reg;
    assign strobe_rise = (strobe_sync_reg[1] == strobe_sync_reg[2]) && strobe_sync_reg[2]
                         && !strobe_level_reg;

    // ************************************************************
    // Framing mode decision
    // ************************************************************
    pllsh_mode_t mode_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= PLLSH_MODE_UNSET;
        end else if (mode_reg == PLLSH_MODE_UNSET) begin
            if (sclk_rise) begin
                mode_reg <= PLLSH_MODE_OPEN;                              // [R23]
            end else if (strobe_rise) begin
                mode_reg <= PLLSH_MODE_LEGACY;                            // [R23]
            end
        end
    end

    assign multi_mode = (mode_reg == PLLSH_MODE_OPEN);

    // ************************************************************
    // Frame shifter and commit
    // ************************************************************
    pllsh_frame_t frame_reg;
    logic [5:0]   bit_cnt_reg;
    logic         commit;
    logic         soft_reset;
    logic         shift_en;

    assign shift_en   = sclk_rise && !strobe_level_reg && mode_reg != PLLSH_MODE_LEGACY;
    assign commit     = strobe_rise && multi_mode && (bit_cnt_reg == 6'(FRAME_BITS))
                        && (frame_reg.chip == OWN_CHIP);                  // [R25]
    assign soft_reset = commit && (frame_reg.addr == ADDR_POINTER)
                        && frame_reg.data[SOFT_RESET_BIT];                // [R22]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_reg   <= '0;
            bit_cnt_reg <= COUNT_RESET;
        end else if (strobe_rise || soft_reset) begin
            bit_cnt_reg <= COUNT_RESET;
        end else if (shift_en) begin
            frame_reg   <= pllsh_frame_t'({frame_reg[30:0], sdi_sync_reg[2]}); // [R4] [R5]
            if (bit_cnt_reg != 6'h3f) begin
                bit_cnt_reg <= bit_cnt_reg + 6'h01;
            end
        end
    end

    // ************************************************************
    // Register file
    // ************************************************************
    logic [DATA_W-1:0] regs_reg [0:(1<<ADDR_W)-1];
    logic [4:0]        pointer_reg;
    logic [15:0]       forward_reg;
    logic [1:0]        rate_reg;
    logic              send_req;

    function automatic logic [DATA_W-1:0] read_value(input logic [4:0] addr);
        logic [DATA_W-1:0] value;
        value = regs_reg[addr];
        case (addr)
            ADDR_POINTER:   value = IDENTITY_VALUE;                       // [R20]
            ADDR_FORWARD:   value = {8'h00, forward_reg};                 // [R24]
            ADDR_LINK_RATE: value = {regs_reg[addr][23:15], rate_reg, regs_reg[addr][12:0]};
            ADDR_SWITCH:    value = {16'h0000, switch_settings};
            default:        value = regs_reg[addr];
        endcase
        return value;
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < (1 << ADDR_W); gi++) begin : g_regs
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    regs_reg[gi] <= REG_RESET;
                end else if (commit && frame_reg.addr == 5'(gi)
                             && 5'(gi) != ADDR_POINTER && 5'(gi) != ADDR_FORWARD) begin
                    regs_reg[gi] <= frame_reg.data;                       // [R7]
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pointer_reg <= POINTER_RESET;
        end else if (soft_reset) begin
            pointer_reg <= POINTER_RESET;                                 // [R22]
        end else if (commit && frame_reg.addr == ADDR_POINTER) begin
            pointer_reg <= frame_reg.data[4:0];                           // [R21]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_reg <= RATE_RESET;
        end else if (commit && frame_reg.addr == ADDR_LINK_RATE) begin
            rate_reg <= frame_reg.data[RATE_MSB:RATE_LSB];                // [R14]
        end
    end

    // Host write has priority; calibration touches payload only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            forward_reg <= FORWARD_RESET;
        end else if (commit && frame_reg.addr == ADDR_FORWARD) begin
            forward_reg <= frame_reg.data[15:0];                          // [R13] [R19]
        end else if (cal_payload_valid) begin
            forward_reg[PAY_MSB:PAY_LSB] <= cal_payload;                  // [R16] [R17]
        end
    end

    assign send_req = (commit && frame_reg.addr == ADDR_FORWARD) || cal_payload_valid;

    // ************************************************************
    // Readback path
    // ************************************************************
    logic [DATA_W-1:0] out_shift_reg;
    logic              serial_mode_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_shift_reg <= REG_RESET;
        end else if (shift_en) begin
            if (bit_cnt_reg == COUNT_RESET) begin
                out_shift_reg <= read_value(pointer_reg);                 // [R1] [R2]
            end else begin
                out_shift_reg <= {out_shift_reg[22:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_mode_reg <= 1'b0;
        end else if (strobe_rise || soft_reset) begin
            serial_mode_reg <= 1'b0;                                      // [R11]
        end else if (shift_en) begin
            serial_mode_reg <= 1'b1;                                      // [R10]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_or_serial_out <= 1'b0;
        end else if (serial_mode_reg) begin
            lock_or_serial_out <= out_shift_reg[DATA_W-1];                // [R10]
        end else begin
            lock_or_serial_out <= lock_indicator;                         // [R11]
        end
    end

    // ************************************************************
    // Forwarding link
    // ************************************************************
    pllsh_link_state_t link_state_reg;
    logic [3:0]        div_cnt_reg;
    logic              link_tick;
    logic              pending_reg;
    logic [15:0]       link_shift_reg;
    logic [4:0]        bits_left_reg;
    pllsh_link_t       link_reg;

    // Half period is 2**rate clock cycles; default gives a quarter of the reference
    assign link_tick = (div_cnt_reg == 4'((4'h1 << rate_reg) - 4'h1));    // [R14]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_reg <= 4'h0;
        end else if (link_tick) begin
            div_cnt_reg <= 4'h0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 4'h1;
        end
    end

    // A new request wins over the clear when a packet starts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_reg <= 1'b0;
        end else if (send_req) begin
            pending_reg <= 1'b1;
        end else if (link_state_reg == PLLSH_LINK_IDLE && link_tick) begin
            pending_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            link_state_reg <= PLLSH_LINK_IDLE;
            link_shift_reg <= FORWARD_RESET;
            bits_left_reg  <= 5'h00;
            link_reg       <= '0;
        end else if (link_tick) begin
            case (link_state_reg)
                PLLSH_LINK_IDLE: begin
                    if (pending_reg) begin
                        link_shift_reg  <= {forward_reg[14:0], 1'b0};
                        link_reg.data   <= forward_reg[PKT_W-1];          // [R13] [R15]
                        link_reg.enable <= 1'b1;
                        link_reg.clk    <= 1'b0;
                        bits_left_reg   <= 5'(PKT_W);
                        link_state_reg  <= PLLSH_LINK_SHIFT;
                    end
                end
                PLLSH_LINK_SHIFT: begin
                    if (!link_reg.clk) begin
                        link_reg.clk <= 1'b1;
                    end else begin
                        link_reg.clk  <= 1'b0;
                        bits_left_reg <= bits_left_reg - 5'h01;
                        if (bits_left_reg == 5'h01) begin
                            link_reg.enable <= 1'b0;
                            link_reg.data   <= 1'b0;
                            link_state_reg  <= PLLSH_LINK_IDLE;
                        end else begin
                            link_reg.data  <= link_shift_reg[PKT_W-1];    // [R13]
                            link_shift_reg <= {link_shift_reg[14:0], 1'b0};
                        end
                    end
                end
                default: begin
                    link_state_reg <= PLLSH_LINK_IDLE;
                end
            endcase
        end
    end

    assign internal_forward_link = link_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    int rise_cnt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rise_cnt <= 0;
        end else if (link_state_reg == PLLSH_LINK_IDLE) begin
            rise_cnt <= 0;
        end else if (link_tick && !link_reg.clk) begin
            rise_cnt <= rise_cnt + 1;
        end
    end

    sequence s_addr_frame;
        commit && frame_reg.addr == ADDR_POINTER && !frame_reg.data[SOFT_RESET_BIT];
    endsequence

    sequence s_forward_write;
        commit && frame_reg.addr == ADDR_FORWARD;
    endsequence

    a_pointer_load: assert property (@(posedge clk) disable iff (!rst_n)       // [R21]
        s_addr_frame |=> pointer_reg == $past(frame_reg.data[4:0]))
        else $error("pointer not loaded from address-zero write");

    a_soft_reset: assert property (@(posedge clk) disable iff (!rst_n)         // [R22]
        soft_reset |=> pointer_reg == POINTER_RESET && bit_cnt_reg == COUNT_RESET)
        else $error("soft reset did not clear serial logic");

    a_foreign_chip: assert property (@(posedge clk) disable iff (!rst_n)       // [R25]
        strobe_rise && frame_reg.chip != OWN_CHIP && !cal_payload_valid
        |=> $stable(forward_reg) && $stable(pointer_reg))
        else $error("frame for another chip changed registers");

    a_forward_send: assert property (@(posedge clk) disable iff (!rst_n)       // [R13]
        s_forward_write |-> ##[1:20] link_reg.enable)
        else $error("forward write did not start link");

    a_link_length: assert property (@(posedge clk) disable iff (!rst_n)        // [R13]
        $fell(link_reg.enable) |-> rise_cnt == PKT_W || $past(rise_cnt) == PKT_W)
        else $error("link packet not sixteen clocks");

    a_cal_payload: assert property (@(posedge clk) disable iff (!rst_n)        // [R16]
        cal_payload_valid && !(commit && frame_reg.addr == ADDR_FORWARD)
        |=> forward_reg[6:0] == $past(forward_reg[6:0])
        && forward_reg[PAY_MSB:PAY_LSB] == $past(cal_payload))
        else $error("calibration touched select or index");

    a_lock_restore: assert property (@(posedge clk) disable iff (!rst_n)       // [R11]
        strobe_rise |=> ##1 lock_or_serial_out == $past(lock_indicator))
        else $error("lock indication not restored after strobe");

    a_readback_data: assert property (@(posedge clk) disable iff (!rst_n)      // [R10]
        serial_mode_reg |=> lock_or_serial_out == $past(out_shift_reg[DATA_W-1]))
        else $error("serial data not on shared pin");

    a_mode_locked: assert property (@(posedge clk) disable iff (!rst_n)        // [R23]
        mode_reg != PLLSH_MODE_UNSET |=> $stable(mode_reg))
        else $error("framing mode changed after decision");

    a_identity_read: assert property (@(posedge clk) disable iff (!rst_n)      // [R20]
        shift_en && bit_cnt_reg == COUNT_RESET && pointer_reg == ADDR_POINTER
        |=> out_shift_reg == IDENTITY_VALUE)
        else $error("identity not returned at address zero");

endmodule

/* tb/pllsh_host_model.sv */
// Host controller model that drives the serial frame pins and captures read bits.
// Assumes clk at 40 MHz; the serial clock half period is four clk cycles.
`timescale 1ns/10ps

module pllsh_host_model (
    input  wire logic clk,
    input  wire logic lock_or_serial_out,
    output logic      serial_clk,
    output logic      frame_strobe,
    output logic      serial_data_in
);
    import pllsh_pkg::*;

    initial begin
        serial_clk     = 1'b0;
        frame_strobe   = 1'b0;
        serial_data_in = 1'b0;
    end

    // ****************************************
    // Frame transfer
    // ****************************************
    // Serial clock stands still low between frames
    task automatic frame(input pllsh_frame_t f, output logic [23:0] rd);
        logic [31:0] bits;
        bits = f;
        rd   = 24'h00_0000;
        for (int i = 0; i < FRAME_BITS; i++) begin
            serial_clk     <= 1'b0;
            serial_data_in <= bits[31 - i];
            repeat (4) @(posedge clk);
            if (i >= 1 && i <= 24) begin
                rd[24 - i] = lock_or_serial_out;
            end
            serial_clk <= 1'b1;
            repeat (4) @(posedge clk);
        end
        serial_clk     <= 1'b0;
        serial_data_in <= ~bits[0];
        frame_strobe   <= 1'b1;
        repeat (4) @(posedge clk);
        frame_strobe   <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    // Lone strobe pulse with the serial clock held low
    task automatic pulse;
        frame_strobe <= 1'b1;
        repeat (4) @(posedge clk);
        frame_strobe <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
endmodule

/* tb/test_pll_serial_host_and_vco_forwarder.sv */
// Self-checking bench for the serial host port and the forwarding link.
// Assumes the host model drives the pins; the bench drives lock, switch and calibration.
`timescale 1ns/10ps
`define PLLSH_CHK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end

module test_pll_serial_host_and_vco_forwarder;
    import pllsh_pkg::*;

    logic        clk;
    logic        rst_n;
    logic        serial_clk;
    logic        frame_strobe;
    logic        serial_data_in;
    logic        lock_indicator;
    logic [7:0]  switch_settings;
    logic        cal_payload_valid;
    logic [8:0]  cal_payload;
    logic        lock_or_serial_out;
    logic        multi_mode;
    pllsh_link_t internal_forward_link;
    logic [23:0] rd;
    logic [15:0] lk_shift;
    logic        lk_clk_q;
    logic        lk_en_q;
    int          n_errors;
    int          n_tests;
    int          n_sends;
    int          lk_cnt;
    int          hi_cnt;
    int          hi_len;

    pllsh_serial_port DUT (
        .clk                   (clk),
        .rst_n                 (rst_n),
        .serial_clk            (serial_clk),
        .frame_strobe          (frame_strobe),
        .serial_data_in        (serial_data_in),
        .lock_indicator        (lock_indicator),
        .switch_settings       (switch_settings),
        .cal_payload_valid     (cal_payload_valid),
        .cal_payload           (cal_payload),
        .lock_or_serial_out    (lock_or_serial_out),
        .multi_mode            (multi_mode),
        .internal_forward_link (internal_forward_link)
    );

    pllsh_host_model host (
        .clk                (clk),
        .lock_or_serial_out (lock_or_serial_out),
        .serial_clk         (serial_clk),
        .frame_strobe       (frame_strobe),
        .serial_data_in     (serial_data_in)
    );

    initial begin
        clk = 1'b0; rst_n = 1'b0; lock_indicator = 1'b0; switch_settings = 8'h00;
        cal_payload_valid = 1'b0; cal_payload = 9'h000; n_errors = 0; n_tests = 0;
        n_sends = 0; lk_cnt = 0; hi_cnt = 0; hi_len = 0; lk_clk_q = 1'b0; lk_en_q = 1'b0;
        lk_shift = 16'h0000;
    end

    always #12.5 clk = ~clk;

    // ****************************************
    // Link monitor
    // ****************************************
    always @(posedge clk) begin
        lk_clk_q <= internal_forward_link.clk;
        lk_en_q  <= internal_forward_link.enable;
        if (internal_forward_link.clk) hi_cnt <= hi_cnt + 1;
        if (internal_forward_link.enable && !lk_en_q) begin
            lk_cnt  <= 0;
            n_sends <= n_sends + 1;
        end
        if (internal_forward_link.enable && internal_forward_link.clk && !lk_clk_q) begin
            lk_shift <= {lk_shift[14:0], internal_forward_link.data};
            lk_cnt   <= lk_cnt + 1;
            hi_cnt   <= 1;
        end
        if (!internal_forward_link.clk && lk_clk_q) hi_len <= hi_cnt;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic write(input logic [23:0] d, input logic [4:0] a);
        host.frame({d, a, OWN_CHIP}, rd);
    endtask

    task automatic read(input logic [4:0] a, input logic [23:0] exp);
        host.frame({19'h0_0000, a, ADDR_POINTER, OWN_CHIP}, rd);
        host.frame({19'h0_0000, a, ADDR_POINTER, OWN_CHIP}, rd);
        `PLLSH_CHK(rd, exp)
        `PLLSH_CHK(lock_or_serial_out, lock_indicator)
    endtask

    task automatic link_check(input logic [15:0] exp, input int half);
        int t;
        t = 0;
        while (internal_forward_link.enable !== 1'b1 && t < 300) begin
            @(posedge clk);
            t++;
        end
        `PLLSH_CHK(internal_forward_link.enable, 1'b1)
        while (internal_forward_link.enable !== 1'b0 && t < 900) begin
            @(posedge clk);
            t++;
        end
        @(posedge clk);
        `PLLSH_CHK(internal_forward_link.enable, 1'b0)
        `PLLSH_CHK(lk_shift, exp)
        `PLLSH_CHK(lk_cnt, 16)
        `PLLSH_CHK(hi_len, half)
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_startup;
        logic [4:0]  order [7] = '{5'h02, 5'h06, 5'h09, ADDR_FORWARD,
                                   5'h03, 5'h04, ADDR_FORWARD};
        logic [23:0] d;
        foreach (order[i]) begin
            d = (order[i] == ADDR_FORWARD) ? 24'h00_0000 : {19'h0_0000, order[i]};
            write(d, order[i]);
            if (order[i] == ADDR_FORWARD) link_check(16'h0000, 2);
        end
        read(5'h02, 24'h00_0002);
        `PLLSH_CHK(multi_mode, 1'b1)
        $display("test startup done");
    endtask

    task automatic t_identity;
        read(ADDR_POINTER, IDENTITY_VALUE);
        host.frame({24'h00_0000, ADDR_POINTER, OWN_CHIP}, rd);
        `PLLSH_CHK(rd, IDENTITY_VALUE)
        $display("test identity done");
    endtask

    task automatic t_forward;
        write(24'h00_7f10, ADDR_FORWARD);
        link_check(16'h7f10, 2);
        read(ADDR_FORWARD, 24'h00_7f10);
        cal_payload       <= 9'h1ab;
        cal_payload_valid <= 1'b1;
        @(posedge clk);
        cal_payload_valid <= 1'b0;
        link_check({9'h1ab, 4'h2, 3'h0}, 2);
        read(ADDR_FORWARD, {8'h00, 9'h1ab, 4'h2, 3'h0});
        $display("test forward done");
    endtask

    task automatic t_chip;
        int n0;
        n0 = n_sends;
        host.frame({24'h00_1234, ADDR_FORWARD, 3'h1}, rd);
        repeat (100) @(posedge clk);
        `PLLSH_CHK(n_sends, n0)
        read(ADDR_FORWARD, {8'h00, 9'h1ab, 4'h2, 3'h0});
        $display("test chip done");
    endtask

    task automatic t_switch;
        switch_settings <= 8'h9c;
        read(ADDR_SWITCH, 24'h00_009c);
        write({8'h00, 8'h9c, 1'b0, 4'h0, 3'h0}, ADDR_FORWARD);
        link_check(16'h9c00, 2);
        $display("test switch done");
    endtask

    task automatic t_soft;
        write({18'h0_0000, 1'b1, ADDR_FORWARD}, ADDR_POINTER);
        host.frame({24'h00_0000, ADDR_FORWARD, 3'h1}, rd);
        `PLLSH_CHK(rd, IDENTITY_VALUE)
        $display("test soft done");
    endtask

    task automatic t_rate;
        write(24'h00_4000, ADDR_LINK_RATE);
        write(24'h00_0123, ADDR_FORWARD);
        link_check(16'h0123, 4);
        lock_indicator <= 1'b0;
        repeat (3) @(posedge clk);
        `PLLSH_CHK(lock_or_serial_out, 1'b0)
        $display("test rate done");
    endtask

    // Hard reset, then a strobe first: frames must be ignored afterwards
    task automatic t_legacy;
        int n0;
        n0 = n_sends;
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        host.pulse();
        write(24'h00_0321, ADDR_FORWARD);
        repeat (100) @(posedge clk);
        `PLLSH_CHK(multi_mode, 1'b0)
        `PLLSH_CHK(n_sends, n0)
        `PLLSH_CHK(lock_or_serial_out, lock_indicator)
        $display("test legacy done");
    endtask

    task automatic close_out;
        $display("errors=%0d tests=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        `PLLSH_CHK(lock_or_serial_out, 1'b0)
        `PLLSH_CHK(internal_forward_link, 3'h0)
        `PLLSH_CHK(multi_mode, 1'b0)
        rst_n          <= 1'b1;
        lock_indicator <= 1'b1;
        repeat (4) @(posedge clk);
        `PLLSH_CHK(lock_or_serial_out, 1'b1)
        t_startup();
        t_identity();
        t_forward();
        t_chip();
        t_switch();
        t_soft();
        t_rate();
        t_legacy();
        close_out();
    end

    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        close_out();
    end
endmodule
